// ---- hdl/fram_reg_cmd.sv ----
// Register-access command decoder of a serial memory slave (single-bit SPI, mode 0)
// Assumes host drives chip select, serial clock and data; pins asynchronous to clk_sys
`timescale 1ns/10ps
`include "fram_reg_map.svh"
module fram_reg_cmd (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic soft_reset,
  input wire logic cs_pin_n,
  input wire logic sck_pin,
  input wire logic si_pin,
  input wire logic wp_pin_n,
  input wire logic busy_in,
  input wire fram_reg_pkg::byte_t status_two_in,
  output logic so_out,
  output logic so_oe,
  output fram_reg_pkg::byte_t status_one,
  output fram_reg_pkg::byte_t config_one,
  output fram_reg_pkg::byte_t config_two,
  output fram_reg_pkg::byte_t config_four,
  output fram_reg_pkg::byte_t config_five,
  output logic write_refused
);
  import fram_reg_pkg::*;

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_DATA,
    ST_DUMMY,
    ST_SHIFT,
    ST_IGNORE
  } cmd_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and byte assembly
  logic cs_n;
  logic sck_rise;
  logic sck_fall;
  logic si;
  logic cs_last_ff;
  logic [7:0] rx_byte;
  logic rx_done;

  link_sync u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .cs_pin_n(cs_pin_n),
    .sck_pin(sck_pin),
    .si_pin(si_pin),
    .cs_n(cs_n),
    .sck_rise(sck_rise),
    .sck_fall(sck_fall),
    .si(si)
  );

  logic wp_meta_ff;
  logic wp_ff;
  logic busy_meta_ff;
  logic busy_ff;

  shift_byte u_shift (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clear(cs_n),
    .sample(sck_rise && !cs_n),
    .bit_in(si),
    .byte_out(rx_byte),
    .byte_done(rx_done)
  );

  wire cs_rise = cs_n && !cs_last_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and command state
  cmd_state_e state_ff;
  cmd_state_e nxt_state;
  logic [7:0] opcode_ff;
  logic [23:0] addr_ff;
  logic [1:0] addr_cnt_ff;
  logic [7:0] data_ff;
  logic data_ok_ff;
  logic extra_ff;
  logic [7:0] tx_ff;
  logic [3:0] dummy_ff;
  logic [7:0] sr1_vol_ff;
  logic [7:0] sr1_nv_ff;
  logic [7:0] cr1_ff;
  logic [7:0] cr1_nv_ff;
  logic [7:0] cr2_ff;
  logic [7:0] cr2_nv_ff;
  logic [7:0] cr4_ff;
  logic [7:0] cr4_nv_ff;
  logic [7:0] cr5_ff;
  logic [7:0] cr5_nv_ff;
  logic refused_ff;

  // Register image selected by a generic address low byte
  function automatic logic [7:0] pick_reg(input logic [7:0] sel, input logic [7:0] sr1,
      input logic [7:0] sr2, input logic [7:0] c1, input logic [7:0] c2,
      input logic [7:0] c4, input logic [7:0] c5);
    case (sel)
      `GADDR_SR1: pick_reg = sr1;
      `GADDR_SR2: pick_reg = sr2;
      `GADDR_CR1: pick_reg = c1;
      `GADDR_CR2: pick_reg = c2;
      `GADDR_CR4: pick_reg = c4;
      `GADDR_CR5: pick_reg = c5;
      default: pick_reg = 8'h00;
    endcase
  endfunction : pick_reg

  wire write_enable_latch = sr1_vol_ff[`SR1_WEL_BIT];
  wire [7:0] sr1_live = {sr1_vol_ff[7:1], busy_ff};
  wire [7:0] sr2_live = busy_ff ? 8'h00 : status_two_in;
  wire protect_lock = sr1_vol_ff[`SR1_SWD_BIT] && !wp_ff;
  wire write_allowed = write_enable_latch && !protect_lock;
  wire [3:0] dummy_count = {2'h0, cr5_ff[`CR5_RLC_LO_BIT +: 2]};
  wire is_ded_read = (rx_byte == `OPC_STATUS_ONE_READ) || (rx_byte == `OPC_STATUS_TWO_READ)
      || (rx_byte == `OPC_CONFIG_ONE_READ) || (rx_byte == `OPC_CONFIG_TWO_READ)
      || (rx_byte == `OPC_CONFIG_FOUR_READ) || (rx_byte == `OPC_CONFIG_FIVE_READ);
  wire is_addr_cmd = (rx_byte == `OPC_GENERIC_WRITE) || (rx_byte == `OPC_GENERIC_READ);
  wire is_write_cmd = (opcode_ff == `OPC_STATUS_ONE_WRITE) || (opcode_ff == `OPC_GENERIC_WRITE);
  wire addr_page_ok = (addr_ff[23:8] == {`GADDR_VOL_PAGE, 8'h00})
      || (addr_ff[23:8] == {8'h00, `GADDR_NV_PAGE});
  wire addr_nv = (addr_ff[23:16] == `GADDR_NV_PAGE);
  wire [7:0] gen_sel = addr_page_ok ? addr_ff[7:0] : 8'hFF;

  // Read data for the opcode just taken; volatile copies only
  wire [7:0] ded_data = (rx_byte == `OPC_STATUS_ONE_READ) ? sr1_live :
      (rx_byte == `OPC_STATUS_TWO_READ) ? sr2_live :
      (rx_byte == `OPC_CONFIG_ONE_READ) ? cr1_ff :
      (rx_byte == `OPC_CONFIG_TWO_READ) ? cr2_ff :
      (rx_byte == `OPC_CONFIG_FOUR_READ) ? cr4_ff : cr5_ff;
  wire [7:0] gen_data = pick_reg(gen_sel, sr1_live, sr2_live, cr1_ff, cr2_ff,
      cr4_ff, cr5_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OPCODE: begin
        if (rx_done) begin
          if (rx_byte == `OPC_STATUS_ONE_WRITE) begin
            nxt_state = ST_DATA;
          end else if (is_addr_cmd) begin
            nxt_state = ST_ADDR;
          end else if (is_ded_read) begin
            nxt_state = ST_DUMMY;
          end else begin
            nxt_state = ST_IGNORE;
          end
        end
      end
      ST_ADDR: begin
        if (rx_done && addr_cnt_ff == 2'(`ADDR_BYTES - 1)) begin
          nxt_state = (opcode_ff == `OPC_GENERIC_READ) ? ST_DUMMY : ST_DATA;
        end
      end
      ST_DATA: begin
        if (rx_done) begin
          nxt_state = ST_IGNORE;
        end
      end
      ST_DUMMY: begin
        if (dummy_ff == 4'h0 && sck_fall) begin
          nxt_state = ST_SHIFT;
        end
      end
      ST_SHIFT: nxt_state = ST_SHIFT;
      ST_IGNORE: nxt_state = ST_IGNORE;
      default: nxt_state = ST_OPCODE;
    endcase
    if (cs_n) begin
      nxt_state = ST_OPCODE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing and serial shifting
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_ff <= ST_OPCODE;
      cs_last_ff <= 1'b1;
      wp_meta_ff <= 1'b1;
      wp_ff <= 1'b1;
      busy_meta_ff <= 1'b0;
      busy_ff <= 1'b0;
      opcode_ff <= 8'h00;
      addr_ff <= 24'h000000;
      addr_cnt_ff <= 2'h0;
      data_ff <= 8'h00;
      data_ok_ff <= 1'b0;
      extra_ff <= 1'b0;
      tx_ff <= 8'h00;
      dummy_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      cs_last_ff <= cs_n;
      wp_meta_ff <= wp_pin_n;
      wp_ff <= wp_meta_ff;
      busy_meta_ff <= busy_in;
      busy_ff <= busy_meta_ff;
      if (cs_n) begin
        addr_cnt_ff <= 2'h0;
        data_ok_ff <= 1'b0;
        extra_ff <= 1'b0;
      end
      if (state_ff == ST_OPCODE && rx_done) begin
        opcode_ff <= rx_byte;
        tx_ff <= ded_data;
        dummy_ff <= dummy_count;
      end
      if (state_ff == ST_ADDR && rx_done) begin
        addr_ff <= {addr_ff[15:0], rx_byte};
        addr_cnt_ff <= addr_cnt_ff + 2'h1;
        dummy_ff <= dummy_count;
      end
      if (state_ff == ST_DATA && rx_done) begin
        data_ff <= rx_byte;
        data_ok_ff <= 1'b1;
      end
      if (state_ff == ST_IGNORE && sck_rise && !cs_n) begin
        extra_ff <= 1'b1;
      end
      if (state_ff == ST_DUMMY && dummy_ff != 4'h0 && sck_fall) begin
        dummy_ff <= dummy_ff - 4'h1;
      end
      if (state_ff == ST_DUMMY && dummy_ff == 4'h0 && opcode_ff == `OPC_GENERIC_READ) begin
        tx_ff <= gen_data;
      end
      if (state_ff == ST_SHIFT && sck_fall) begin
        tx_ff <= {tx_ff[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register updates at chip-select rising edge
  wire opcode_only = (addr_cnt_ff == 2'h0) && !data_ok_ff && (state_ff == ST_IGNORE);
  wire do_set_wel = cs_rise && opcode_only && opcode_ff == `OPC_WRITE_ENABLE && !extra_ff;
  wire do_clr_wel = cs_rise && opcode_only && opcode_ff == `OPC_WRITE_DISABLE && !extra_ff
      && !busy_ff;
  wire wr_frame = cs_rise && data_ok_ff && !extra_ff && is_write_cmd;
  wire do_write = wr_frame && write_allowed && !busy_ff;
  wire do_sr1_write = do_write && (opcode_ff == `OPC_STATUS_ONE_WRITE
      || (addr_page_ok && addr_ff[7:0] == `GADDR_SR1));
  wire do_gen_write = do_write && opcode_ff == `OPC_GENERIC_WRITE && addr_page_ok;
  wire do_sr1_nv = do_sr1_write && (opcode_ff == `OPC_STATUS_ONE_WRITE || addr_nv);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sr1_nv_ff <= `SR1_DEFAULT;
      cr1_nv_ff <= `CR1_DEFAULT;
      cr2_nv_ff <= `CR2_DEFAULT;
      cr4_nv_ff <= `CR4_DEFAULT;
      cr5_nv_ff <= `CR5_DEFAULT;
    end else if (do_write) begin
      if (do_sr1_nv) begin
        sr1_nv_ff <= {data_ff[7:2], 2'h0};
      end
      if (do_gen_write && addr_nv && addr_ff[7:0] == `GADDR_CR1) begin
        cr1_nv_ff <= data_ff;
      end
      if (do_gen_write && addr_nv && addr_ff[7:0] == `GADDR_CR2) begin
        cr2_nv_ff <= data_ff;
      end
      if (do_gen_write && addr_nv && addr_ff[7:0] == `GADDR_CR4) begin
        cr4_nv_ff <= data_ff;
      end
      if (do_gen_write && addr_nv && addr_ff[7:0] == `GADDR_CR5) begin
        cr5_nv_ff <= data_ff;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n || soft_reset) begin
      sr1_vol_ff <= sr1_nv_ff;
      cr1_ff <= cr1_nv_ff;
      cr2_ff <= cr2_nv_ff;
      cr4_ff <= cr4_nv_ff;
      cr5_ff <= cr5_nv_ff;
      refused_ff <= 1'b0;
    end else begin
      refused_ff <= wr_frame && !do_write;
      if (do_set_wel) begin
        sr1_vol_ff[`SR1_WEL_BIT] <= 1'b1;
      end
      if (do_clr_wel) begin
        sr1_vol_ff[`SR1_WEL_BIT] <= 1'b0;
      end
      if (do_sr1_write) begin
        sr1_vol_ff <= {data_ff[7:2], 2'h0};
      end else if (do_write) begin
        sr1_vol_ff[`SR1_WEL_BIT] <= 1'b0;
      end
      if (do_gen_write && addr_ff[7:0] == `GADDR_CR1) begin
        cr1_ff <= data_ff;
      end
      if (do_gen_write && addr_ff[7:0] == `GADDR_CR2) begin
        cr2_ff <= data_ff;
      end
      if (do_gen_write && addr_ff[7:0] == `GADDR_CR4) begin
        cr4_ff <= data_ff;
      end
      if (do_gen_write && addr_ff[7:0] == `GADDR_CR5) begin
        cr5_ff <= data_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      so_out <= 1'b0;
      so_oe <= 1'b0;
      status_one <= 8'h00;
      config_one <= 8'h00;
      config_two <= 8'h00;
      config_four <= 8'h00;
      config_five <= 8'h00;
      write_refused <= 1'b0;
    end else begin
      so_out <= tx_ff[7];
      so_oe <= (state_ff == ST_SHIFT) && !cs_n;
      status_one <= sr1_live;
      config_one <= cr1_ff;
      config_two <= cr2_ff;
      config_four <= cr4_ff;
      config_five <= cr5_ff;
      write_refused <= refused_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  wel_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n || soft_reset)
      do_clr_wel && !do_set_wel |=> !sr1_vol_ff[`SR1_WEL_BIT])
    else $error("enable latch not cleared");
  wel_busy_a: assert property (@(posedge clk_sys) disable iff (!reset_n || soft_reset)
      busy_ff && !do_set_wel && !do_write && sr1_vol_ff[`SR1_WEL_BIT]
      |=> sr1_vol_ff[`SR1_WEL_BIT])
    else $error("enable latch dropped while busy");
  wel_edge_a: assert property (@(posedge clk_sys) disable iff (!reset_n || soft_reset)
      $fell(sr1_vol_ff[`SR1_WEL_BIT]) |-> $past(cs_rise))
    else $error("enable latch cleared off deselect");
  write_locked_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wr_frame && !write_enable_latch |=> $stable(sr1_nv_ff) && $stable(cr5_nv_ff))
    else $error("write taken without latch");
  protect_pin_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wr_frame && protect_lock |=> $stable(sr1_nv_ff))
    else $error("protected status write taken");
  sr1_nv_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      do_sr1_nv |=> sr1_nv_ff == {$past(data_ff[7:2]), 2'h0})
    else $error("nonvolatile status not programmed");
  wel_auto_a: assert property (@(posedge clk_sys) disable iff (!reset_n || soft_reset)
      do_write |=> !sr1_vol_ff[`SR1_WEL_BIT])
    else $error("latch not cleared after write");
  read_data_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_ff == ST_OPCODE && rx_done && rx_byte == `OPC_CONFIG_FIVE_READ
      |=> tx_ff == $past(cr5_ff))
    else $error("config five read data wrong");
  set_wel_a: assert property (@(posedge clk_sys) disable iff (!reset_n || soft_reset)
      do_set_wel && !do_clr_wel |=> sr1_vol_ff[`SR1_WEL_BIT])
    else $error("enable latch not set");
  dummy_cov_c: cover property (@(posedge clk_sys) state_ff == ST_DUMMY && dummy_ff == 4'h2);
  sr1_wr_c: cover property (@(posedge clk_sys) do_sr1_write);
  refuse_c: cover property (@(posedge clk_sys) refused_ff);
  gen_rd_c: cover property (@(posedge clk_sys) state_ff == ST_SHIFT && opcode_ff == 8'h65);
endmodule : fram_reg_cmd

// ---- hdl/fram_reg_map.svh ----
// Opcodes, register field positions, reset values and generic address map
// Assumes inclusion by the package and the design modules
`ifndef FRAM_REG_MAP_SVH
`define FRAM_REG_MAP_SVH
`define OPC_WRITE_ENABLE 8'h06
`define OPC_WRITE_DISABLE 8'h04
`define OPC_STATUS_ONE_WRITE 8'h01
`define OPC_STATUS_ONE_READ 8'h05
`define OPC_STATUS_TWO_READ 8'h07
`define OPC_CONFIG_ONE_READ 8'h35
`define OPC_CONFIG_TWO_READ 8'h3F
`define OPC_CONFIG_FOUR_READ 8'h45
`define OPC_CONFIG_FIVE_READ 8'h5E
`define OPC_GENERIC_WRITE 8'h71
`define OPC_GENERIC_READ 8'h65
`define SR1_WEL_BIT 1
`define SR1_WIP_BIT 0
`define SR1_SWD_BIT 7
`define CR5_RLC_LO_BIT 0
`define ADDR_BYTES 3
`define SR1_DEFAULT 8'h00
`define SR2_DEFAULT 8'h00
`define CR1_DEFAULT 8'h00
`define CR2_DEFAULT 8'h00
`define CR4_DEFAULT 8'h00
`define CR5_DEFAULT 8'h00
`define GADDR_VOL_PAGE 8'h07
`define GADDR_NV_PAGE 8'h00
`define GADDR_SR1 8'h00
`define GADDR_SR2 8'h01
`define GADDR_CR1 8'h02
`define GADDR_CR2 8'h03
`define GADDR_CR4 8'h05
`define GADDR_CR5 8'h06
`endif

// ---- hdl/fram_reg_pkg.sv ----
// Types shared by the register-access command decoder
// Assumes the map header is on the include path
package fram_reg_pkg;
  `include "fram_reg_map.svh"
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    LAT_ZERO,
    LAT_ONE,
    LAT_TWO,
    LAT_THREE
  } reg_latency_e;
endpackage : fram_reg_pkg

// ---- hdl/link_sync.sv ----
// Two-stage synchroniser for link pins plus serial clock edge finder
// Assumes pins are asynchronous to clk_sys
`timescale 1ns/10ps
module link_sync (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cs_pin_n,
  input wire logic sck_pin,
  input wire logic si_pin,
  output logic cs_n,
  output logic sck_rise,
  output logic sck_fall,
  output logic si
);
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic sck_last_ff;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meta_ff <= 3'h5;
      sync_ff <= 3'h5;
      sck_last_ff <= 1'b0;
    end else begin
      meta_ff <= {cs_pin_n, sck_pin, si_pin};
      sync_ff <= meta_ff;
      sck_last_ff <= sync_ff[1];
    end
  end
  assign cs_n = sync_ff[2];
  assign si = sync_ff[0];
  assign sck_rise = sync_ff[1] & ~sck_last_ff;
  assign sck_fall = ~sync_ff[1] & sck_last_ff;
endmodule : link_sync

// ---- hdl/shift_byte.sv ----
// Serial-in byte assembler with bit counter, cleared while deselected
// Assumes one-cycle sample strobes from clk_sys
`timescale 1ns/10ps
module shift_byte (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic sample,
  input wire logic bit_in,
  output logic [7:0] byte_out,
  output logic byte_done
);
  logic [6:0] sh_ff;
  logic [2:0] cnt_ff;
  always_ff @(posedge clk_sys) begin
    if (!reset_n || clear) begin
      sh_ff <= 7'h00;
      cnt_ff <= 3'h0;
    end else if (sample) begin
      sh_ff <= {sh_ff[5:0], bit_in};
      cnt_ff <= cnt_ff + 3'h1;
    end
  end
  assign byte_out = {sh_ff, bit_in};
  assign byte_done = sample && (cnt_ff == 3'h7);
endmodule : shift_byte

// ---- tb/spi_host_model.sv ----
// Single-bit SPI host (mode 0) that frames register-access commands
// Assumes the device samples SI on SCK rise and shifts SO on SCK fall
`timescale 1ns/10ps
module spi_host_model (
  output logic cs_pin_n,
  output logic sck_pin,
  output logic si_pin,
  input wire logic so_out,
  input wire logic so_oe
);
  localparam real HALF_PERIOD = 24.0;

  ////////////////////////////////////////////////////////////////////////////
  // Idle wire state: deselected, serial clock parked low
  initial begin
    cs_pin_n = 1'b1;
    sck_pin = 1'b0;
    si_pin = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame pieces
  task automatic select_dev;
    #(HALF_PERIOD) cs_pin_n <= 1'b0;
    #(HALF_PERIOD);
  endtask : select_dev

  // Bytes go out whole, MSB first
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      si_pin <= b[i];
      #(HALF_PERIOD) sck_pin <= 1'b1;
      #(HALF_PERIOD) sck_pin <= 1'b0;
    end
  endtask : send_byte

  // Skip the dummy cycles, then take one byte on the rising edges
  task automatic recv_byte(input int dummy, output logic [7:0] b);
    b = 8'h00;
    for (int i = 0; i < dummy + 8; i++) begin
      si_pin <= ~si_pin;
      #(HALF_PERIOD) sck_pin <= 1'b1;
      if (i >= dummy) begin
        b = {b[6:0], (so_oe === 1'b1) ? so_out : 1'bx};
      end
      #(HALF_PERIOD) sck_pin <= 1'b0;
    end
  endtask : recv_byte

  // Deselect right after the last bit; released data line flips
  task automatic deselect_dev;
    #(HALF_PERIOD) cs_pin_n <= 1'b1;
    si_pin <= ~si_pin;
    #(HALF_PERIOD * 2);
  endtask : deselect_dev
endmodule : spi_host_model

// ---- tb/fram_register_access_commands_bench.sv ----
// Self-checking bench for the register-access command decoder
// Assumes the SPI host model drives the link pins
`timescale 1ns/10ps
module fram_register_access_commands_bench;
  import fram_reg_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic soft_reset = 1'b0;
  logic wp_pin_n = 1'b1;
  logic busy_in = 1'b0;
  byte_t status_two_in = 8'h00;
  logic cs_pin_n, sck_pin, si_pin, so_out, so_oe, write_refused;
  byte_t status_one, config_one, config_two, config_four, config_five;
  int err_total = 0;
  int tests_run = 0;
  int refused_cnt = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, design and host
  always #2.5 clk_sys = ~clk_sys;

  fram_reg_cmd i_fram_reg_cmd (
    .clk_sys(clk_sys), .reset_n(reset_n), .soft_reset(soft_reset),
    .cs_pin_n(cs_pin_n), .sck_pin(sck_pin), .si_pin(si_pin), .wp_pin_n(wp_pin_n),
    .busy_in(busy_in), .status_two_in(status_two_in), .so_out(so_out), .so_oe(so_oe),
    .status_one(status_one), .config_one(config_one), .config_two(config_two),
    .config_four(config_four), .config_five(config_five), .write_refused(write_refused)
  );

  spi_host_model i_spi_host_model (
    .cs_pin_n(cs_pin_n), .sck_pin(sck_pin), .si_pin(si_pin), .so_out(so_out), .so_oe(so_oe)
  );

  always @(posedge clk_sys) begin
    if (write_refused === 1'b1) begin
      refused_cnt++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic cmd(input logic [7:0] op);
    i_spi_host_model.select_dev();
    i_spi_host_model.send_byte(op);
    i_spi_host_model.deselect_dev();
    cyc(8);
  endtask : cmd

  task automatic wr_sr1(input logic [7:0] v);
    i_spi_host_model.select_dev();
    i_spi_host_model.send_byte(8'h01);
    i_spi_host_model.send_byte(v);
    i_spi_host_model.deselect_dev();
    cyc(8);
  endtask : wr_sr1

  task automatic wr_any(input logic [23:0] a, input logic [7:0] v);
    i_spi_host_model.select_dev();
    i_spi_host_model.send_byte(8'h71);
    for (int i = 2; i >= 0; i--) begin
      i_spi_host_model.send_byte(a[i*8 +: 8]);
    end
    i_spi_host_model.send_byte(v);
    i_spi_host_model.deselect_dev();
    cyc(8);
  endtask : wr_any

  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int dummy,
                    output logic [7:0] b);
    i_spi_host_model.select_dev();
    i_spi_host_model.send_byte(op);
    if (op == 8'h65) begin
      for (int i = 2; i >= 0; i--) begin
        i_spi_host_model.send_byte(a[i*8 +: 8]);
      end
    end
    i_spi_host_model.recv_byte(dummy, b);
    i_spi_host_model.deselect_dev();
    cyc(8);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    logic [7:0] b;
    chk8(status_one, 8'h00, "status one after reset");
    chk8(config_five, 8'h00, "config five after reset");
    rd(8'h05, 24'h0, 0, b);
    chk8(b, 8'h00, "status one read after reset");
  endtask : t_reset

  task automatic t_latch;
    logic [7:0] b;
    cmd(8'h06);
    chk8(status_one, 8'h02, "latch set");
    rd(8'h05, 24'h0, 0, b);
    chk8(b, 8'h02, "status one read");
    @(posedge clk_sys) busy_in <= 1'b1;
    cyc(6);
    cmd(8'h04);
    chk8(status_one, 8'h03, "disable while busy");
    @(posedge clk_sys) busy_in <= 1'b0;
    cyc(6);
    i_spi_host_model.select_dev();
    i_spi_host_model.send_byte(8'h04);
    cyc(10);
    chk8(status_one, 8'h02, "latch held until deselect");
    i_spi_host_model.deselect_dev();
    cyc(8);
    chk8(status_one, 8'h00, "latch cleared");
  endtask : t_latch

  task automatic t_sr1_write;
    int c0;
    c0 = refused_cnt;
    wr_sr1(8'h8C);
    chk8(status_one, 8'h00, "write without latch");
    wr_any(24'h070002, 8'h55);
    chk8(config_one, 8'h00, "generic write without latch");
    chk8(8'(refused_cnt - c0), 8'h02, "refusal pulses");
    cmd(8'h06);
    wr_sr1(8'h8C);
    chk8(status_one, 8'h8C, "status one written, latch auto clear");
    @(posedge clk_sys) wp_pin_n <= 1'b0;
    cyc(4);
    cmd(8'h06);
    wr_sr1(8'h00);
    chk8(status_one & 8'hFC, 8'h8C, "locked write ignored");
    @(posedge clk_sys) wp_pin_n <= 1'b1;
    cyc(4);
    cmd(8'h06);
    wr_sr1(8'h04);
    chk8(status_one, 8'h04, "unlocked write");
  endtask : t_sr1_write

  task automatic t_generic;
    cmd(8'h06);
    wr_any(24'h070002, 8'h55);
    chk8(config_one, 8'h55, "volatile generic write");
    cmd(8'h06);
    wr_any(24'h000003, 8'h33);
    chk8(config_two, 8'h33, "nonvolatile generic write");
    @(posedge clk_sys) soft_reset <= 1'b1;
    cyc(2);
    @(posedge clk_sys) soft_reset <= 1'b0;
    cyc(4);
    chk8(config_one, 8'h00, "volatile back to default");
    chk8(config_two, 8'h33, "nonvolatile kept");
    chk8(status_one, 8'h04, "status one kept");
  endtask : t_generic

  task automatic t_reads;
    logic [7:0] ops [6] = '{8'h05, 8'h07, 8'h35, 8'h3F, 8'h45, 8'h5E};
    logic [7:0] exp [6] = '{8'h04, 8'hA5, 8'h00, 8'h33, 8'h5A, 8'h02};
    logic [7:0] b;
    @(posedge clk_sys) status_two_in <= 8'hA5;
    cmd(8'h06);
    wr_any(24'h070005, 8'h5A);
    chk8(config_four, 8'h5A, "config four written");
    cmd(8'h06);
    wr_any(24'h070006, 8'h02);
    chk8(config_five, 8'h02, "latency code written");
    foreach (ops[i]) begin
      rd(ops[i], 24'h0, 2, b);
      chk8(b, exp[i], "dedicated read");
    end
    rd(8'h65, 24'h000006, 2, b);
    chk8(b, 8'h02, "generic read of nonvolatile address");
    rd(8'h65, 24'h070003, 2, b);
    chk8(b, 8'h33, "generic read of volatile address");
    @(posedge clk_sys) busy_in <= 1'b1;
    cyc(6);
    rd(8'h07, 24'h0, 2, b);
    chk8(b, 8'h00, "status two while busy");
    @(posedge clk_sys) busy_in <= 1'b0;
  endtask : t_reads

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, watchdog and main sequence
  task automatic finish_test;
    if (err_total == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  initial begin
    #400000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    cyc(12);
    reset_n <= 1'b1;
    cyc(4);
    t_reset();
    t_latch();
    t_sr1_write();
    t_generic();
    t_reads();
    finish_test();
  end
endmodule : fram_register_access_commands_bench
